// ===== verilog/pcie_dcc_cfg.svh
// register map, field positions and reset values of the device capability/control bank
`ifndef PCIE_DCC_CFG_SVH
`define PCIE_DCC_CFG_SVH
// ---------------------------------------------------------------
// byte addresses and bus answers
// ---------------------------------------------------------------
`define DCC_CAP_OFS      8'hb4
`define DCC_CTRL_OFS     8'hb8
`define DCC_RESP_OKAY    2'h0
`define DCC_RESP_SLVERR  2'h2
// ---------------------------------------------------------------
// capability word fields
// ---------------------------------------------------------------
`define DCC_L0S_HI       8
`define DCC_L0S_LO       6
`define DCC_L1_HI        11
`define DCC_L1_LO        9
`define DCC_ATTN_BTN     12
`define DCC_ATTN_IND     13
`define DCC_PWR_IND      14
`define DCC_SPL_VAL_HI   25
`define DCC_SPL_VAL_LO   18
`define DCC_SPL_SCL_HI   27
`define DCC_SPL_SCL_LO   26
`define DCC_L0S_RST      3'h0
`define DCC_L1_RST       3'h0
// ---------------------------------------------------------------
// control word fields
// ---------------------------------------------------------------
`define DCC_ERR_HI       3
`define DCC_ERR_LO       0
`define DCC_RLX_ORD      4
`define DCC_MPS_HI       7
`define DCC_MPS_LO       5
`define DCC_EXT_TAG      8
`define DCC_PHANTOM      9
`define DCC_AUX_PM       10
`define DCC_NO_SNOOP     11
`define DCC_MRRS_HI      14
`define DCC_MRRS_LO      12
`define DCC_RETRY        15
`define DCC_ERR_RST      4'h0
`define DCC_MPS_RST      3'h0
`define DCC_MRRS_RST     3'h2
`endif

// ===== verilog/dcc_pkg.sv
// types shared by the register bank and its bus ports
package dcc_pkg;
	typedef logic [7:0]  addr_t;
	typedef logic [31:0] data_t;
	typedef logic [3:0]  strb_t;
	typedef logic [1:0]  resp_t;
	typedef enum logic [1:0] {SEL_NONE = 2'h0, SEL_CAP = 2'h1, SEL_CTRL = 2'h2} reg_sel_t;
	typedef enum logic [1:0] {WP_COLLECT = 2'h0, WP_ISSUE = 2'h1, WP_RESP = 2'h2} wr_phase_t;
	typedef enum logic [1:0] {RP_IDLE = 2'h0, RP_ISSUE = 2'h1, RP_RESP = 2'h2} rd_phase_t;
	typedef struct packed {
		wr_phase_t phase;
		logic      awHeld;
		logic      wHeld;
		addr_t     addr;
		data_t     data;
		strb_t     strb;
		logic      awRdy;
		logic      wRdy;
		logic      bVld;
		resp_t     resp;
		logic      en;
	} wr_state_t;
	typedef struct packed {
		rd_phase_t phase;
		addr_t     addr;
		logic      arRdy;
		logic      rVld;
		data_t     data;
		resp_t     resp;
		logic      en;
	} rd_state_t;
	typedef struct packed {
		logic [3:0] errEn;
		logic [2:0] mps;
		logic [2:0] mrrs;
		logic       extTag;
		logic       retry;
		logic       noSnoop;
		logic       relaxed;
		logic       strapDone;
		logic       hp;
		logic [7:0] pwrVal;
		logic [1:0] pwrScale;
	} bank_state_t;
endpackage

// ===== verilog/dcc_axil_write.sv
// axi4-lite write channels: collects address and data, issues one write, answers
`timescale 1ns/1ps
`include "pcie_dcc_cfg.svh"
module dcc_axil_write (
	input  wire logic           clk,
	input  wire logic           rstn,
	input  wire logic           awvalid,
	output logic                awready,
	input  wire dcc_pkg::addr_t awaddr,
	input  wire logic           wvalid,
	output logic                wready,
	input  wire dcc_pkg::data_t wdata,
	input  wire dcc_pkg::strb_t wstrb,
	output logic                bvalid,
	input  wire logic           bready,
	output dcc_pkg::resp_t      bresp,
	output logic                wrEn,
	output dcc_pkg::addr_t      wrAddr,
	output dcc_pkg::data_t      wrData,
	output dcc_pkg::strb_t      wrStrb,
	input  wire logic           wrOk
);
	import dcc_pkg::*;
	wr_state_t q;
	wr_state_t d;
	always_comb begin
		d = q;
		d.en = 1'b0;
		case (q.phase)
			WP_COLLECT: begin
				if (awvalid && q.awRdy) begin
					d.awHeld = 1'b1;
					d.addr = awaddr;
				end
				if (wvalid && q.wRdy) begin
					d.wHeld = 1'b1;
					d.data = wdata;
					d.strb = wstrb;
				end
				if (d.awHeld && d.wHeld) begin
					d.phase = WP_ISSUE;
					d.en = 1'b1;
				end
			end
			WP_ISSUE: begin
				d.bVld = 1'b1;
				d.resp = wrOk ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
				d.awHeld = 1'b0;
				d.wHeld = 1'b0;
				d.phase = WP_RESP;
			end
			WP_RESP: begin
				if (bready) begin
					d.bVld = 1'b0;
					d.phase = WP_COLLECT;
				end
			end
			default: d.phase = WP_COLLECT;
		endcase
		// ready only while collecting, so one write at most is in flight
		d.awRdy = (d.phase == WP_COLLECT) && !d.awHeld;
		d.wRdy = (d.phase == WP_COLLECT) && !d.wHeld;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign awready = q.awRdy;
	assign wready = q.wRdy;
	assign bvalid = q.bVld;
	assign bresp = q.resp;
	assign wrEn = q.en;
	assign wrAddr = q.addr;
	assign wrData = q.data;
	assign wrStrb = q.strb;
endmodule

// ===== verilog/dcc_axil_read.sv
// axi4-lite read channels: takes one address, fetches the word, answers
`timescale 1ns/1ps
`include "pcie_dcc_cfg.svh"
module dcc_axil_read (
	input  wire logic           clk,
	input  wire logic           rstn,
	input  wire logic           arvalid,
	output logic                arready,
	input  wire dcc_pkg::addr_t araddr,
	output logic                rvalid,
	input  wire logic           rready,
	output dcc_pkg::data_t      rdata,
	output dcc_pkg::resp_t      rresp,
	output logic                rdEn,
	output dcc_pkg::addr_t      rdAddr,
	input  wire dcc_pkg::data_t rdData,
	input  wire logic           rdOk
);
	import dcc_pkg::*;
	rd_state_t q;
	rd_state_t d;
	always_comb begin
		d = q;
		d.en = 1'b0;
		case (q.phase)
			RP_IDLE: begin
				if (arvalid && q.arRdy) begin
					d.addr = araddr;
					d.en = 1'b1;
					d.phase = RP_ISSUE;
				end
			end
			RP_ISSUE: begin
				d.rVld = 1'b1;
				d.data = rdData;
				d.resp = rdOk ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
				d.phase = RP_RESP;
			end
			RP_RESP: begin
				if (rready) begin
					d.rVld = 1'b0;
					d.phase = RP_IDLE;
				end
			end
			default: d.phase = RP_IDLE;
		endcase
		d.arRdy = (d.phase == RP_IDLE);
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign arready = q.arRdy;
	assign rvalid = q.rVld;
	assign rdata = q.data;
	assign rresp = q.resp;
	assign rdEn = q.en;
	assign rdAddr = q.addr;
endmodule

// ===== verilog/pcie_device_cap_ctrl_regs.sv
// device capability and device control register bank behind an axi4-lite slave
`timescale 1ns/1ps
`include "pcie_dcc_cfg.svh"
module pcie_device_cap_ctrl_regs (
	input  wire logic           clk,
	input  wire logic           rstn,
	input  wire logic           awvalid,
	output logic                awready,
	input  wire dcc_pkg::addr_t awaddr,
	input  wire logic           wvalid,
	output logic                wready,
	input  wire dcc_pkg::data_t wdata,
	input  wire dcc_pkg::strb_t wstrb,
	output logic                bvalid,
	input  wire logic           bready,
	output dcc_pkg::resp_t      bresp,
	input  wire logic           arvalid,
	output logic                arready,
	input  wire dcc_pkg::addr_t araddr,
	output logic                rvalid,
	input  wire logic           rready,
	output dcc_pkg::data_t      rdata,
	output dcc_pkg::resp_t      rresp,
	input  wire logic           hotplugStrap,
	input  wire logic           forwardBridge,
	input  wire logic           slotMsgValid,
	input  wire logic [7:0]     slotMsgValue,
	input  wire logic [1:0]     slotMsgScale,
	output logic [3:0]          errRptEn,
	output logic [2:0]          maxPayloadCode,
	output logic [2:0]          maxReadReqCode,
	output logic                extTagEn,
	output logic                cfgRetryEn,
	output logic                noSnoopSet,
	output logic                relaxedOrderSet
);
	import dcc_pkg::*;

	// ---------------------------------------------------------------
	// address decode
	// ---------------------------------------------------------------
	function automatic reg_sel_t regSel(input addr_t a);
		reg_sel_t s;
		s = SEL_NONE;
		if (a == `DCC_CAP_OFS) begin
			s = SEL_CAP;
		end else if (a == `DCC_CTRL_OFS) begin
			s = SEL_CTRL;
		end
		return s;
	endfunction

	// ---------------------------------------------------------------
	// bus ports
	// ---------------------------------------------------------------
	logic  wrEn;
	addr_t wrAddr;
	data_t wrData;
	strb_t wrStrb;
	logic  wrOk;
	logic  rdEn;
	addr_t rdAddr;
	data_t rdData;
	logic  rdOk;

	dcc_axil_write dcc_axil_write_inst (
		.clk     (clk),
		.rstn    (rstn),
		.awvalid (awvalid),
		.awready (awready),
		.awaddr  (awaddr),
		.wvalid  (wvalid),
		.wready  (wready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.bvalid  (bvalid),
		.bready  (bready),
		.bresp   (bresp),
		.wrEn    (wrEn),
		.wrAddr  (wrAddr),
		.wrData  (wrData),
		.wrStrb  (wrStrb),
		.wrOk    (wrOk)
	);

	dcc_axil_read dcc_axil_read_inst (
		.clk     (clk),
		.rstn    (rstn),
		.arvalid (arvalid),
		.arready (arready),
		.araddr  (araddr),
		.rvalid  (rvalid),
		.rready  (rready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rdEn    (rdEn),
		.rdAddr  (rdAddr),
		.rdData  (rdData),
		.rdOk    (rdOk)
	);

	// ---------------------------------------------------------------
	// register state
	// ---------------------------------------------------------------
	bank_state_t q;
	bank_state_t d;
	logic        ctrlWrLow;
	logic        ctrlWrHigh;
	logic        capRead;
	logic        ctrlRead;
	logic        strapHp;
	data_t       capWord;
	data_t       ctrlWord;

	// hot-plug indicators exist only for the forward bridge
	assign strapHp = hotplugStrap && forwardBridge;
	assign ctrlWrLow = wrEn && (regSel(wrAddr) == SEL_CTRL) && wrStrb[0];
	assign ctrlWrHigh = wrEn && (regSel(wrAddr) == SEL_CTRL) && wrStrb[1];
	assign capRead = rdEn && (regSel(rdAddr) == SEL_CAP);
	assign ctrlRead = rdEn && (regSel(rdAddr) == SEL_CTRL);
	// writes to the read-only capability word are accepted and dropped
	assign wrOk = (regSel(wrAddr) != SEL_NONE);
	assign rdOk = (regSel(rdAddr) != SEL_NONE);

	always_comb begin
		d = q;
		// strap is caught once, on the first edge after reset release
		if (!q.strapDone) begin
			d.strapDone = 1'b1;
			d.hp = strapHp;
		end
		if (slotMsgValid) begin
			d.pwrVal = slotMsgValue;
			d.pwrScale = slotMsgScale;
		end
		if (ctrlWrLow) begin
			d.errEn = wrData[`DCC_ERR_HI:`DCC_ERR_LO];
			d.mps = wrData[`DCC_MPS_HI:`DCC_MPS_LO];
		end
		if (ctrlWrHigh) begin
			d.extTag = wrData[`DCC_EXT_TAG];
			d.mrrs = wrData[`DCC_MRRS_HI:`DCC_MRRS_LO];
			d.retry = wrData[`DCC_RETRY];
		end
		// attributes the bridge never uses stay cleared whatever is written
		d.noSnoop = 1'b0;
		d.relaxed = 1'b0;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q <= '{errEn: `DCC_ERR_RST, mps: `DCC_MPS_RST, mrrs: `DCC_MRRS_RST, default: '0};
		end else begin
			q <= d;
		end
	end

	// ---------------------------------------------------------------
	// read words
	// ---------------------------------------------------------------
	always_comb begin
		capWord = '0;
		capWord[`DCC_L0S_HI:`DCC_L0S_LO] = `DCC_L0S_RST;
		capWord[`DCC_L1_HI:`DCC_L1_LO] = `DCC_L1_RST;
		capWord[`DCC_ATTN_BTN] = q.hp;
		capWord[`DCC_ATTN_IND] = q.hp;
		capWord[`DCC_PWR_IND] = q.hp;
		capWord[`DCC_SPL_VAL_HI:`DCC_SPL_VAL_LO] = q.pwrVal;
		capWord[`DCC_SPL_SCL_HI:`DCC_SPL_SCL_LO] = q.pwrScale;
	end

	always_comb begin
		ctrlWord = '0;
		ctrlWord[`DCC_ERR_HI:`DCC_ERR_LO] = q.errEn;
		ctrlWord[`DCC_RLX_ORD] = q.relaxed;
		ctrlWord[`DCC_MPS_HI:`DCC_MPS_LO] = q.mps;
		ctrlWord[`DCC_EXT_TAG] = q.extTag;
		ctrlWord[`DCC_PHANTOM] = 1'b0;
		ctrlWord[`DCC_AUX_PM] = 1'b0;
		ctrlWord[`DCC_NO_SNOOP] = q.noSnoop;
		ctrlWord[`DCC_MRRS_HI:`DCC_MRRS_LO] = q.mrrs;
		ctrlWord[`DCC_RETRY] = q.retry;
	end

	// unmapped reads return zero with an error answer
	always_comb begin
		case (regSel(rdAddr))
			SEL_CAP:  rdData = capWord;
			SEL_CTRL: rdData = ctrlWord;
			default:  rdData = '0;
		endcase
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign errRptEn = q.errEn;
	assign maxPayloadCode = q.mps;
	assign maxReadReqCode = q.mrrs;
	assign extTagEn = q.extTag;
	assign cfgRetryEn = q.retry;
	assign noSnoopSet = q.noSnoop;
	assign relaxedOrderSet = q.relaxed;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	sequence ctrlWriteLow;
		ctrlWrLow;
	endsequence

	sequence ctrlWriteHigh;
		ctrlWrHigh;
	endsequence

	sequence quietLow;
		!ctrlWrLow [*2];
	endsequence

	sequence quietHigh;
		!ctrlWrHigh [*2];
	endsequence

	sequence ctrlReadIssue;
		ctrlRead;
	endsequence

	sequence capReadIssue;
		capRead;
	endsequence

	a_l1_lat_code: assert property (capRead |-> rdData[11:9] == 3'h0)
		else $error("l1 latency code not zero");

	a_button_strap: assert property ($rose(q.strapDone) |-> q.hp == $past(strapHp))
		else $error("hot-plug strap not captured");

	a_button_read: assert property (capRead |-> rdData[12] == q.hp)
		else $error("attention button bit wrong");

	a_indicator_bits: assert property (capRead |-> rdData[14:13] == {2{rdData[12]}})
		else $error("indicator bits differ from button bit");

	a_hp_stable: assert property (q.strapDone |=> $stable(q.hp))
		else $error("hot-plug capability changed after strap");

	a_pwr_capture: assert property (slotMsgValid |=>
		q.pwrVal == $past(slotMsgValue) && q.pwrScale == $past(slotMsgScale))
		else $error("slot power limit not captured");

	a_pwr_hold: assert property (!slotMsgValid |=> $stable(q.pwrVal) && $stable(q.pwrScale))
		else $error("slot power limit changed without message");

	a_pwr_read: assert property (capRead |-> rdData[27:18] == {q.pwrScale, q.pwrVal})
		else $error("slot power limit read wrong");

	a_err_enables: assert property (ctrlWriteLow |=> errRptEn == $past(wrData[3:0]))
		else $error("error enables not written");

	a_no_snoop: assert property (ctrlRead |-> !rdData[11] && !rdData[4] && !noSnoopSet && !relaxedOrderSet)
		else $error("no-snoop or relaxed ordering set");

	a_payload_size: assert property (ctrlWriteLow |=> maxPayloadCode == $past(wrData[7:5]))
		else $error("payload size not written");

	a_payload_hold: assert property (quietLow |-> $stable(maxPayloadCode))
		else $error("payload size changed without write");

	a_read_req_size: assert property (ctrlWriteHigh |=> maxReadReqCode == $past(wrData[14:12]))
		else $error("read request size not written");

	a_mrrs_after_reset: assert property ($rose(q.strapDone) && !$past(ctrlWrHigh) |-> maxReadReqCode == 3'h2)
		else $error("read request size reset value wrong");

	a_fixed_zeros: assert property (ctrlRead |-> rdData[10:9] == 2'h0)
		else $error("phantom or aux power bit set");

	a_l0s_lat_code: assert property (capRead |-> rdData[8:6] == 3'h0)
		else $error("l0s latency code not zero");

	a_ext_tag: assert property (ctrlWriteHigh |=> extTagEn == $past(wrData[8]))
		else $error("extended tag enable not written");

	a_retry_write: assert property (ctrlWriteHigh |=> cfgRetryEn == $past(wrData[15]))
		else $error("retry enable not written");

	a_reserved_zero: assert property (capRead |-> rdData[17:15] == 3'h0 && rdData[31:28] == 4'h0)
		else $error("reserved capability bits set");

	a_ctrl_upper: assert property (ctrlRead |-> rdData[31:16] == 16'h0000)
		else $error("upper half of control word set");

	a_err_hold: assert property (quietLow |-> $stable(errRptEn))
		else $error("error enables changed without write");

	a_mrrs_hold: assert property (quietHigh |-> $stable(maxReadReqCode))
		else $error("read request size changed without write");

	a_tag_hold: assert property (quietHigh |-> $stable(extTagEn))
		else $error("extended tag enable changed without write");

	a_retry_hold: assert property (quietHigh |-> $stable(cfgRetryEn))
		else $error("retry enable changed without write");

	a_lane_low_kept: assert property (wrEn && wrAddr == `DCC_CTRL_OFS && !wrStrb[0] |=>
		$stable(errRptEn) && $stable(maxPayloadCode))
		else $error("low control byte moved without its lane");

	a_lane_high_kept: assert property (wrEn && wrAddr == `DCC_CTRL_OFS && !wrStrb[1] |=>
		$stable(maxReadReqCode) && $stable(extTagEn) && $stable(cfgRetryEn))
		else $error("high control byte moved without its lane");

	a_hp_before_strap: assert property (!q.strapDone |-> !q.hp)
		else $error("hot-plug bits set before strap capture");

	a_cap_wr_drop: assert property (wrEn && wrAddr == `DCC_CAP_OFS |=>
		$stable(q.pwrVal) || $past(slotMsgValid))
		else $error("capability write reached the power limit");

	a_rd_ctrl_low: assert property (ctrlReadIssue |=> rvalid &&
		rdata[3:0] == $past(errRptEn) && rdata[7:5] == $past(maxPayloadCode))
		else $error("control read low fields wrong");

	a_rd_ctrl_high: assert property (ctrlReadIssue |=> rvalid &&
		rdata[14:12] == $past(maxReadReqCode) && rdata[8] == $past(extTagEn) && rdata[15] == $past(cfgRetryEn))
		else $error("control read high fields wrong");

	a_rd_cap_word: assert property (capReadIssue |=> rvalid &&
		rdata[27:18] == {$past(q.pwrScale), $past(q.pwrVal)} && rdata[14:12] == {3{$past(q.hp)}})
		else $error("capability read fields wrong");

endmodule

// ===== testbench/pcie_device_cap_ctrl_regs_tb.sv
// self-checking bench for the device capability/control register bank
`timescale 1ns/1ps
`include "pcie_dcc_cfg.svh"
module pcie_device_cap_ctrl_regs_tb;
	import dcc_pkg::*;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic       clk, rstn, awvalid, wvalid, bready, arvalid, rready;
	logic       hotplugStrap, forwardBridge, slotMsgValid;
	addr_t      awaddr, araddr;
	data_t      wdata, rdata;
	strb_t      wstrb;
	logic [7:0] slotMsgValue;
	logic [1:0] slotMsgScale;
	logic       awready, wready, bvalid, arready, rvalid;
	resp_t      bresp, rresp;
	logic [3:0] errRptEn;
	logic [2:0] maxPayloadCode, maxReadReqCode;
	logic       extTagEn, cfgRetryEn, noSnoopSet, relaxedOrderSet;
	data_t      rdDataQ[$];
	resp_t      rdRespQ[$];
	resp_t      wrRespQ[$];
	int         n_fail, compares;
	integer     seed;
	logic [15:0] ctrlExp;
	logic       hp;
	data_t      d;
	strb_t      s;
	logic [7:0] v;
	logic [1:0] sc;

	pcie_device_cap_ctrl_regs pcie_device_cap_ctrl_regs_inst (.clk(clk), .rstn(rstn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .hotplugStrap(hotplugStrap), .forwardBridge(forwardBridge),
		.slotMsgValid(slotMsgValid), .slotMsgValue(slotMsgValue), .slotMsgScale(slotMsgScale),
		.errRptEn(errRptEn), .maxPayloadCode(maxPayloadCode), .maxReadReqCode(maxReadReqCode),
		.extTagEn(extTagEn), .cfgRetryEn(cfgRetryEn), .noSnoopSet(noSnoopSet),
		.relaxedOrderSet(relaxedOrderSet));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ---------------------------------------------------------------
	// checking
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// watcher: takes the oldest note whenever a response handshake happens
	always @(posedge clk) begin
		if (rvalid === 1'b1 && rready) begin
			if (rdDataQ.size() == 0) check("unexpected read", 32'h1, 32'h0);
			else begin
				check("rdata", rdata, rdDataQ.pop_front());
				check("rresp", rresp, rdRespQ.pop_front());
			end
		end
		if (bvalid === 1'b1 && bready) begin
			if (wrRespQ.size() == 0) check("unexpected write", 32'h1, 32'h0);
			else check("bresp", bresp, wrRespQ.pop_front());
		end
	end

	// bounded wait so a silent slave cannot hang the run
	initial begin
		#300us;
		n_fail++;
		print_verdict();
	end
	// ---------------------------------------------------------------
	// bus cycles
	// ---------------------------------------------------------------
	task automatic wrReg(input addr_t a, input data_t dat, input strb_t st, input resp_t r);
		wrRespQ.push_back(r);
		@(posedge clk);
		awvalid <= 1'b1;
		awaddr  <= a;
		wvalid  <= 1'b1;
		wdata   <= dat;
		wstrb   <= st;
		bready  <= 1'b1;
		do begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid === 1'b1 && bready));
		bready <= 1'b0;
	endtask

	task automatic rdReg(input addr_t a, input data_t exp, input resp_t r);
		rdDataQ.push_back(exp);
		rdRespQ.push_back(r);
		@(posedge clk);
		arvalid <= 1'b1;
		araddr  <= a;
		rready  <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid === 1'b1 && rready));
		rready <= 1'b0;
	endtask

	task automatic doRst(input logic h, input logic f);
		@(posedge clk);
		rstn          <= 1'b0;
		hotplugStrap  <= h;
		forwardBridge <= f;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (2) @(posedge clk);
	endtask

	task automatic sendMsg(input logic [7:0] val, input logic [1:0] scl);
		@(posedge clk);
		slotMsgValid <= 1'b1;
		slotMsgValue <= val;
		slotMsgScale <= scl;
	endtask

	// reserved fields and latency codes always zero; bits 14:12 follow the strap
	function automatic data_t capExp(input logic h, input logic [7:0] val, input logic [1:0] scl);
		return {4'h0, scl, val, 3'h0, {3{h}}, 12'h000};
	endfunction

	// only writable bits move; read-only zeros ignore the data
	function automatic logic [15:0] ctrlNext(input logic [15:0] old, input data_t dat, input strb_t st);
		logic [15:0] m;
		m = {{8{st[1]}}, {8{st[0]}}} & 16'hf1ef;
		return (old & ~m) | (dat[15:0] & m);
	endfunction

	task automatic checkOuts();
		#1;
		check("errRptEn", errRptEn, ctrlExp[3:0]);
		check("maxPayloadCode", maxPayloadCode, ctrlExp[7:5]);
		check("extTagEn", extTagEn, ctrlExp[8]);
		check("maxReadReqCode", maxReadReqCode, ctrlExp[14:12]);
		check("cfgRetryEn", cfgRetryEn, ctrlExp[15]);
		check("noSnoopSet", {noSnoopSet, relaxedOrderSet}, 2'h0);
	endtask
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		{rstn, awvalid, wvalid, bready, arvalid, rready, slotMsgValid} = '0;
		{hotplugStrap, forwardBridge} = 2'h0;
		awaddr = '0; araddr = '0; wdata = '0; wstrb = '0;
		slotMsgValue = '0; slotMsgScale = '0;
		n_fail = 0; compares = 0;
		seed = 32'h31bebd7b;
		// every strap combination, each behind a fresh reset
		for (int k = 0; k < 4; k++) begin
			doRst(k[0], k[1]);
			hp = k[0] & k[1];
			ctrlExp = 16'h2000;
			rdReg(`DCC_CAP_OFS, capExp(hp, 8'h00, 2'h0), `DCC_RESP_OKAY);
			rdReg(`DCC_CTRL_OFS, {16'h0, ctrlExp}, `DCC_RESP_OKAY);
			checkOuts();
		end
		wrReg(`DCC_CTRL_OFS, 32'hffffffff, 4'hf, `DCC_RESP_OKAY);
		ctrlExp = ctrlNext(ctrlExp, 32'hffffffff, 4'hf);
		checkOuts();
		rdReg(`DCC_CTRL_OFS, {16'h0, ctrlExp}, `DCC_RESP_OKAY);
		// random data and lanes, reserved size codes included
		for (int i = 0; i < 12; i++) begin
			d = $random(seed);
			s = $random(seed);
			wrReg(`DCC_CTRL_OFS, d, s, `DCC_RESP_OKAY);
			ctrlExp = ctrlNext(ctrlExp, d, s);
			checkOuts();
			rdReg(`DCC_CTRL_OFS, {16'h0, ctrlExp}, `DCC_RESP_OKAY);
		end
		// unmapped and misaligned places are refused and change nothing
		wrReg(8'hbc, $random(seed), 4'hf, `DCC_RESP_SLVERR);
		wrReg(8'hb9, 32'h00000000, 4'hf, `DCC_RESP_SLVERR);
		rdReg(`DCC_CTRL_OFS, {16'h0, ctrlExp}, `DCC_RESP_OKAY);
		rdReg(8'hbc, 32'h0, `DCC_RESP_SLVERR);
		// capability word ignores writes
		wrReg(`DCC_CAP_OFS, 32'hffffffff, 4'hf, `DCC_RESP_OKAY);
		rdReg(`DCC_CAP_OFS, capExp(1'b1, 8'h00, 2'h0), `DCC_RESP_OKAY);
		// two back-to-back messages on each pass, where the last wins
		for (int j = 0; j < 4; j++) begin
			v = $random(seed);
			sc = j[1:0];
			sendMsg(v ^ 8'h5a, ~sc);
			sendMsg(v, sc);
			@(posedge clk);
			slotMsgValid <= 1'b0;
			rdReg(`DCC_CAP_OFS, capExp(1'b1, v, sc), `DCC_RESP_OKAY);
		end
		repeat (4) @(posedge clk);
		print_verdict();
	end
endmodule
